// ### hw/vtod_decoder.sv
// Three-operand vector instruction decoder: one registered stage from fetch to execution
`timescale 1ns/1ps
`include "vtod_params.svh"

module vtod_decoder (
   input  wire logic                  mclk,
   input  wire logic                  rst_n,
   input  wire logic                  instr_valid,
   input  wire logic [63:0]           instr_word,
   input  wire logic [31:0]           literal_word,
   output logic                       dec_valid,
   output logic                       format_match,
   output logic                       scalar_result,
   output logic [9:0]                 opcode,
   output logic [7:0]                 vector_destination,
   output logic [6:0]                 scalar_destination,
   output logic                       clamp_flag,
   output vtod_pkg::vtod_outmul_t     output_multiplier,
   output logic                       literal_used,
   output vtod_pkg::vtod_src_kind_t   src_kind [3],
   output logic [7:0]                 src_index [3],
   output logic [31:0]                src_value [3]
);

   // ************************************************************
   // Combinational decode of the presented word
   // ************************************************************
   localparam int unsigned SRC_LO [3] = '{`VTOD_FIRST_SEL_LO, `VTOD_SECOND_SEL_LO, `VTOD_THIRD_SEL_LO};

   vtod_pkg::vtod_state_t    st_q;
   vtod_pkg::vtod_state_t    st_d;
   vtod_pkg::vtod_src_kind_t dk [3];
   logic [7:0]               di [3];
   logic [31:0]              dv [3];
   logic [8:0]               sel [3];
   logic [9:0]               opc;
   logic                     is_sr;

   // Membership of the scalar-result opcode set
   function automatic logic vtod_is_scalar_result(input logic [9:0] op);
      return (op == `VTOD_OP_DIV_SCALE32) || (op == `VTOD_OP_DIV_SCALE64) ||
             (op == `VTOD_OP_MAD_U64)     || (op == `VTOD_OP_MAD_I64)     ||
             (op == `VTOD_OP_ADD_CO)      || (op == `VTOD_OP_SUB_CO)      ||
             (op == `VTOD_OP_SUBREV_CO);
   endfunction : vtod_is_scalar_result

   assign opc   = instr_word[`VTOD_OPC_HI:`VTOD_OPC_LO];
   assign is_sr = vtod_is_scalar_result(opc);

   // Same map for all three selectors, so one decoder per slot
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_src
         assign sel[g] = instr_word[SRC_LO[g] +: `VTOD_SRC_W];
         vtod_src_decode u_src (
            .sel          (sel[g]),
            .literal_word (literal_word),
            .kind         (dk[g]),
            .index        (di[g]),
            .value        (dv[g])
         );
      end
   endgenerate

   // ************************************************************
   // Next state: out_valid follows instr_valid every cycle; the other fields only update on a taken instruction
   // ************************************************************
   always_comb
   begin
      st_d           = st_q;
      st_d.out_valid = instr_valid;
      if (instr_valid)
      begin
         st_d.format_match       = (instr_word[`VTOD_ENC_HI:`VTOD_ENC_LO] == `VTOD_ENC_CODE);
         st_d.opcode             = opc;
         st_d.scalar_result      = is_sr;
         st_d.vector_destination = instr_word[`VTOD_VEC_DEST_HI:`VTOD_VEC_DEST_LO];
         st_d.clamp_flag         = instr_word[`VTOD_CLAMP_BIT];
         // General variant has no scalar destination, so it reads as zero
         st_d.scalar_destination = is_sr ? instr_word[`VTOD_SCL_DEST_HI:`VTOD_SCL_DEST_LO] : 7'h00;
         st_d.output_multiplier  =
            vtod_pkg::vtod_outmul_t'(instr_word[`VTOD_OUT_MUL_HI:`VTOD_OUT_MUL_LO]);
         st_d.literal_used       = 1'b0;
         for (int i = 0; i < 3; i++)
         begin
            st_d.src[i].kind  = dk[i];
            st_d.src[i].index = di[i];
            st_d.src[i].value = dv[i];
            if (dk[i] == vtod_pkg::VTOD_SRC_LITERAL)
               st_d.literal_used = 1'b1;
         end
      end
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   // Outputs straight from the state register
   assign dec_valid          = st_q.out_valid;
   assign format_match       = st_q.format_match;
   assign scalar_result      = st_q.scalar_result;
   assign opcode             = st_q.opcode;
   assign vector_destination = st_q.vector_destination;
   assign scalar_destination = st_q.scalar_destination;
   assign clamp_flag         = st_q.clamp_flag;
   assign output_multiplier  = st_q.output_multiplier;
   assign literal_used       = st_q.literal_used;

   generate
      for (g = 0; g < 3; g++)
      begin : g_out
         assign src_kind[g]  = st_q.src[g].kind;
         assign src_index[g] = st_q.src[g].index;
         assign src_value[g] = st_q.src[g].value;
      end
   endgenerate

endmodule : vtod_decoder

// ### hw/vtod_src_decode.sv
// Combinational map from one 9-bit source selector to operand kind, index and value
`timescale 1ns/1ps
`include "vtod_params.svh"

module vtod_src_decode (
   input  wire logic [8:0]            sel,
   input  wire logic [31:0]           literal_word,
   output vtod_pkg::vtod_src_kind_t   kind,
   output logic [7:0]                 index,
   output logic [31:0]                value
);

   // Float table indexed by selector minus 240
   function automatic logic [31:0] vtod_float_const(input logic [3:0] k);
      logic [31:0] f;
      f = 32'h00000000;
      unique case (k)
         4'h0: f = `VTOD_FLT_HALF;
         4'h1: f = `VTOD_FLT_NHALF;
         4'h2: f = `VTOD_FLT_ONE;
         4'h3: f = `VTOD_FLT_NONE;
         4'h4: f = `VTOD_FLT_TWO;
         4'h5: f = `VTOD_FLT_NTWO;
         4'h6: f = `VTOD_FLT_FOUR;
         4'h7: f = `VTOD_FLT_NFOUR;
         4'h8: f = `VTOD_FLT_INV2PI;
         default: f = 32'h00000000;
      endcase
      return f;
   endfunction : vtod_float_const

   // ************************************************************
   // Range decode, checked from the top so vector space wins first
   // ************************************************************
   always_comb
   begin
      kind  = vtod_pkg::VTOD_SRC_RESERVED;
      index = sel[7:0];
      value = 32'h00000000;
      if (sel >= `VTOD_SEL_VECTOR_MIN)
      begin
         kind  = vtod_pkg::VTOD_SRC_VECTOR;
         index = sel[7:0];
      end
      else if (sel == `VTOD_SEL_LITERAL)
      begin
         kind  = vtod_pkg::VTOD_SRC_LITERAL;
         value = literal_word;
      end
      else if (sel >= `VTOD_SEL_STAT_MIN && sel <= `VTOD_SEL_STAT_MAX)
         kind = vtod_pkg::VTOD_SRC_STATUS;
      else if (sel == `VTOD_SEL_SDWA || sel == `VTOD_SEL_DPP16)
         kind = vtod_pkg::VTOD_SRC_EXTENSION;
      else if (sel >= `VTOD_SEL_FLT_MIN && sel <= `VTOD_SEL_FLT_MAX)
      begin
         kind  = vtod_pkg::VTOD_SRC_FLOAT_CONST;
         index = 8'(sel - `VTOD_SEL_FLT_MIN);
         value = vtod_float_const(index[3:0]);
      end
      else if (sel == `VTOD_SEL_WAVE_ID)
         kind = vtod_pkg::VTOD_SRC_STATUS;
      else if (sel >= `VTOD_SEL_APER_MIN && sel <= `VTOD_SEL_APER_MAX)
      begin
         kind  = vtod_pkg::VTOD_SRC_APERTURE;
         index = 8'(sel - `VTOD_SEL_APER_MIN);
      end
      else if (sel >= `VTOD_SEL_EXT_MIN && sel <= `VTOD_SEL_EXT_MAX)
         kind = vtod_pkg::VTOD_SRC_EXTENSION;
      else if (sel > `VTOD_SEL_NEG_MAX)
         kind = vtod_pkg::VTOD_SRC_RESERVED;
      else if (sel > `VTOD_SEL_POS_MAX)
      begin
         kind  = vtod_pkg::VTOD_SRC_INT_CONST;
         value = `VTOD_INT_BIAS_NEG - {23'h000000, sel};
      end
      else if (sel > `VTOD_SEL_ZERO)
      begin
         kind  = vtod_pkg::VTOD_SRC_INT_CONST;
         value = {23'h000000, sel} - `VTOD_INT_BIAS_POS;
      end
      else if (sel == `VTOD_SEL_ZERO)
         kind = vtod_pkg::VTOD_SRC_INT_CONST;
      else if (sel == `VTOD_SEL_EXEC_LO || sel == `VTOD_SEL_EXEC_HI)
      begin
         kind  = vtod_pkg::VTOD_SRC_EXEC;
         index = {7'h00, sel[0]};
      end
      else if (sel == `VTOD_SEL_NULL)
         kind = vtod_pkg::VTOD_SRC_NULL;
      else if (sel == `VTOD_SEL_M0)
         kind = vtod_pkg::VTOD_SRC_M0;
      else if (sel >= `VTOD_SEL_TRAP_MIN)
      begin
         kind  = vtod_pkg::VTOD_SRC_TRAP;
         index = 8'(sel - `VTOD_SEL_TRAP_MIN);
      end
      else if (sel == `VTOD_SEL_VCC_LO || sel == `VTOD_SEL_VCC_HI)
      begin
         kind  = vtod_pkg::VTOD_SRC_VCC;
         index = {7'h00, sel[0]};
      end
      else
      begin
         kind  = vtod_pkg::VTOD_SRC_SCALAR;
         index = sel[7:0];
      end
   end

endmodule : vtod_src_decode

// ### include/vtod_params.svh
// Constants of the vector three-operand decoder: field positions, codes and selector ranges
// What this block does
// - Bits 31..26 equal 110101 mark the general three-operand format.
// - First source selector is the 9-bit field at bits 40..32.
// - Selectors 0..105 address the scalar register of the same index.
// - Selectors 108..123 address trap temp registers 0..15 in order.
// - Selectors 129..192 give inline integers 1..64, selector minus 128.
// - Selectors 193..208 give inline integers -1..-16, 192 minus selector.
// - Selectors 235..238 read shared_aperture_base, shared_aperture_limit, private_aperture_base, private_aperture_limit.
// - Second source selector at bits 49..41, same value map as first.
// - Third source selector at bits 58..50, same value map as first.
// - Output multiplier bits 60..59: none, times two, times four, halve.
// - Scalar-result variant names a scalar destination in bits 14..8.
// - Scalar-result variant only for carry, borrow, divide-scale, wide multiply-add opcodes.
// - All other opcodes use the general variant with clamp and output multiplier.
`ifndef VTOD_PARAMS_SVH
`define VTOD_PARAMS_SVH

// ************************************************************
// Instruction field positions
// ************************************************************
`define VTOD_ENC_HI        31
`define VTOD_ENC_LO        26
`define VTOD_ENC_CODE      6'h35
`define VTOD_OPC_HI        25
`define VTOD_OPC_LO        16
`define VTOD_VEC_DEST_HI   7
`define VTOD_VEC_DEST_LO   0
`define VTOD_SCL_DEST_HI   14
`define VTOD_SCL_DEST_LO   8
`define VTOD_CLAMP_BIT     15
`define VTOD_FIRST_SEL_LO  32
`define VTOD_SECOND_SEL_LO 41
`define VTOD_THIRD_SEL_LO  50
`define VTOD_SRC_W         9
`define VTOD_OUT_MUL_HI    60
`define VTOD_OUT_MUL_LO    59

// ************************************************************
// Scalar-result opcodes
// ************************************************************
`define VTOD_OP_DIV_SCALE32 10'h16D
`define VTOD_OP_DIV_SCALE64 10'h16E
`define VTOD_OP_MAD_U64     10'h176
`define VTOD_OP_MAD_I64     10'h177
`define VTOD_OP_ADD_CO      10'h30F
`define VTOD_OP_SUB_CO      10'h310
`define VTOD_OP_SUBREV_CO   10'h319

// ************************************************************
// Selector ranges and constants
// ************************************************************
`define VTOD_SEL_SCALAR_MAX 9'h069
`define VTOD_SEL_VCC_LO     9'h06A
`define VTOD_SEL_VCC_HI     9'h06B
`define VTOD_SEL_TRAP_MIN   9'h06C
`define VTOD_SEL_TRAP_MAX   9'h07B
`define VTOD_SEL_M0         9'h07C
`define VTOD_SEL_NULL       9'h07D
`define VTOD_SEL_EXEC_LO    9'h07E
`define VTOD_SEL_EXEC_HI    9'h07F
`define VTOD_SEL_ZERO       9'h080
`define VTOD_SEL_POS_MAX    9'h0C0
`define VTOD_SEL_NEG_MAX    9'h0D0
`define VTOD_SEL_EXT_MIN    9'h0E9
`define VTOD_SEL_EXT_MAX    9'h0EA
`define VTOD_SEL_APER_MIN   9'h0EB
`define VTOD_SEL_APER_MAX   9'h0EE
`define VTOD_SEL_WAVE_ID    9'h0EF
`define VTOD_SEL_FLT_MIN    9'h0F0
`define VTOD_SEL_FLT_MAX    9'h0F8
`define VTOD_SEL_SDWA       9'h0F9
`define VTOD_SEL_DPP16      9'h0FA
`define VTOD_SEL_STAT_MIN   9'h0FB
`define VTOD_SEL_STAT_MAX   9'h0FD
`define VTOD_SEL_LITERAL    9'h0FF
`define VTOD_SEL_VECTOR_MIN 9'h100
`define VTOD_INT_BIAS_POS   32'h00000080
`define VTOD_INT_BIAS_NEG   32'h000000C0
`define VTOD_FLT_HALF       32'h3F000000
`define VTOD_FLT_NHALF      32'hBF000000
`define VTOD_FLT_ONE        32'h3F800000
`define VTOD_FLT_NONE       32'hBF800000
`define VTOD_FLT_TWO        32'h40000000
`define VTOD_FLT_NTWO       32'hC0000000
`define VTOD_FLT_FOUR       32'h40800000
`define VTOD_FLT_NFOUR      32'hC0800000
`define VTOD_FLT_INV2PI     32'h3E22F983

`endif

// ### include/vtod_pkg.sv
// Types shared by the vector three-operand decoder files
package vtod_pkg;

   // ************************************************************
   // Operand kinds
   // ************************************************************
   typedef enum logic [3:0] {
      VTOD_SRC_SCALAR,
      VTOD_SRC_VCC,
      VTOD_SRC_TRAP,
      VTOD_SRC_M0,
      VTOD_SRC_NULL,
      VTOD_SRC_EXEC,
      VTOD_SRC_INT_CONST,
      VTOD_SRC_APERTURE,
      VTOD_SRC_FLOAT_CONST,
      VTOD_SRC_LITERAL,
      VTOD_SRC_VECTOR,
      VTOD_SRC_STATUS,
      VTOD_SRC_EXTENSION,
      VTOD_SRC_RESERVED
   } vtod_src_kind_t;

   // Result scaling requested by the output multiplier
   typedef enum logic [1:0] {
      VTOD_OUTMUL_NONE,
      VTOD_OUTMUL_MUL2,
      VTOD_OUTMUL_MUL4,
      VTOD_OUTMUL_DIV2
   } vtod_outmul_t;

   // One decoded source operand
   typedef struct packed {
      vtod_src_kind_t kind;
      logic [7:0]     index;
      logic [31:0]    value;
   } vtod_src_t;

   // Whole registered state of the decoder
   typedef struct packed {
      logic          out_valid;
      logic          format_match;
      logic          scalar_result;
      logic [9:0]    opcode;
      logic [7:0]    vector_destination;
      logic [6:0]    scalar_destination;
      logic          clamp_flag;
      vtod_outmul_t  output_multiplier;
      logic          literal_used;
      vtod_src_t [2:0] src;
   } vtod_state_t;

endpackage : vtod_pkg

// ### verif/tb.sv
// Self-checking bench for the vector three-operand decoder
`timescale 1ns/1ps
module tb;
   // ********
   // Signals and instances
   // ********
   logic                     mclk = 1'b0, rst_n = 1'b0, send = 1'b0;
   logic [63:0]              word = 64'h0, instr_word;
   logic [31:0]              lit = 32'h0, literal_word;
   logic                     instr_valid, dec_valid, format_match, scalar_result, clamp_flag, literal_used;
   logic [9:0]               opcode;
   logic [7:0]               vector_destination;
   logic [6:0]               scalar_destination;
   vtod_pkg::vtod_outmul_t   output_multiplier;
   vtod_pkg::vtod_src_kind_t src_kind [3];
   logic [7:0]               src_index [3];
   logic [31:0]              src_value [3];
   int                       mismatches = 0, checks_done = 0, cycles = 0;

   always #10 mclk = ~mclk;

   vtod_fetch_model vtod_fetch_model_inst (.mclk, .send, .word, .lit, .instr_valid, .instr_word, .literal_word);
   vtod_decoder vtod_decoder_inst (.mclk, .rst_n, .instr_valid, .instr_word, .literal_word, .dec_valid,
      .format_match, .scalar_result, .opcode, .vector_destination, .scalar_destination, .clamp_flag,
      .output_multiplier, .literal_used, .src_kind, .src_index, .src_value);

   // ********
   // Shared tasks
   // ********
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp

   function automatic logic [63:0] mk(input logic [9:0] opc, input logic [8:0] s0, input logic [8:0] s1,
      input logic [8:0] s2, input logic [1:0] om, input logic cl, input logic [6:0] sd, input logic [7:0] vd);
      return {3'h0, om, s2, s1, s0, 6'h35, opc, cl, sd, vd};
   endfunction : mk

   // One word in, outputs settled just after the taking edge
   task automatic xfer(input logic [63:0] w);
      @(posedge mclk);
      #1;
      send = 1'b1;
      word = w;
      @(posedge mclk);
      #1;
      send = 1'b0;
   endtask : xfer

   // Expected {covered, kind, index, value} for every selector, special registers and reserved codes too
   function automatic logic [44:0] sel_exp(input logic [8:0] s);
      logic [31:0] fv [9];
      fv = '{32'h3F000000, 32'hBF000000, 32'h3F800000, 32'hBF800000, 32'h40000000, 32'hC0000000,
             32'h40800000, 32'hC0800000, 32'h3E22F983};
      if (s <= 9'h069) return {5'h10, s[7:0], 32'h0};
      if (s inside {[9'h06C:9'h07B]}) return {5'h12, s[7:0] - 8'h6C, 32'h0};
      if (s inside {9'h06A, 9'h06B}) return {5'h11, 7'h0, s[0], 32'h0};
      if (s == 9'h07C) return {5'h13, s[7:0], 32'h0};
      if (s == 9'h07D) return {5'h14, s[7:0], 32'h0};
      if (s inside {9'h07E, 9'h07F}) return {5'h15, 7'h0, s[0], 32'h0};
      if (s == 9'h080) return {5'h16, s[7:0], 32'h0};
      if (s inside {[9'h081:9'h0C0]}) return {5'h16, s[7:0], {23'h0, s} - 32'h80};
      if (s inside {[9'h0C1:9'h0D0]}) return {5'h16, s[7:0], 32'hC0 - {23'h0, s}};
      if (s inside {[9'h0EB:9'h0EE]}) return {5'h17, s[7:0] - 8'hEB, 32'h0};
      if (s inside {[9'h0F0:9'h0F8]}) return {5'h18, s[7:0] - 8'hF0, fv[s - 9'h0F0]};
      if (s == 9'h0FF) return {5'h19, 8'hFF, lit};
      if (s[8]) return {5'h1A, s[7:0], 32'h0};
      if (s inside {9'h0EF, [9'h0FB:9'h0FD]}) return {5'h1B, s[7:0], 32'h0};
      if (s inside {9'h0E9, 9'h0EA, 9'h0F9, 9'h0FA}) return {5'h1C, s[7:0], 32'h0};
      if (s inside {[9'h0D1:9'h0E8], 9'h0FE}) return {5'h1D, s[7:0], 32'h0};
      return 45'h0;
   endfunction : sel_exp

   // ********
   // Scenarios
   // ********
   task automatic t_fields();
      for (int o = 0; o < 4; o++)
      begin
         xfer(mk(10'h140, 9'h0C1, 9'h06C, 9'h100, o[1:0], o[0], 7'h55, 8'hF0 + o[7:0]));
         cmp(format_match, 32'h1, "format");
         cmp(output_multiplier, o, "multiplier");
         cmp({clamp_flag, vector_destination}, {o[0], 8'hF0 + o[7:0]}, "clamp and destination");
         cmp({scalar_result, scalar_destination}, 32'h0, "general variant");
      end
      // Fetch lines now carry garbage, so a result that tracks them shows up here
      @(posedge mclk);
      #1;
      cmp({dec_valid, vector_destination}, 32'hF3, "hold");
      xfer(mk(10'h140, 9'h0, 9'h0, 9'h0, 2'h0, 1'b0, 7'h0, 8'h0) ^ 64'h0C000000);
      cmp({dec_valid, format_match}, 32'h2, "other encoding");
      $display("field test done");
   endtask : t_fields

   task automatic t_sres();
      logic [9:0] ops [8];
      ops = '{10'h16D, 10'h16E, 10'h176, 10'h177, 10'h30F, 10'h310, 10'h319, 10'h16F};
      for (int i = 0; i < 8; i++)
      begin
         xfer(mk(ops[i], 9'h100, 9'h101, 9'h102, 2'h0, 1'b1, 7'h40 + i[6:0], 8'h00));
         cmp(scalar_result, i < 7, "variant");
         cmp(opcode, ops[i], "opcode");
         cmp(scalar_destination, (i < 7) ? 32'h40 + i : 32'h0, "scalar destination");
      end
      $display("variant test done");
   endtask : t_sres

   // Every covered selector back to back, rotating over the three source fields
   task automatic t_sel();
      logic [44:0] e;
      logic [8:0]  q [$];
      logic [8:0]  s;
      int          k;
      lit = 32'h5A0F3C96;
      for (int n = 0; n < 512; n++)
      begin
         e = sel_exp(n[8:0]);
         if (e[44]) q.push_back(n[8:0]);
      end
      for (int i = 0; i <= q.size(); i++)
      begin
         @(posedge mclk);
         #1;
         if (i > 0)
         begin
            e = sel_exp(q[i - 1]);
            k = (i - 1) % 3;
            cmp(dec_valid, 32'h1, "strobe");
            cmp(src_kind[k], e[43:40], "kind");
            cmp(src_index[k], e[39:32], "index");
            cmp(src_value[k], e[31:0], "value");
            cmp(literal_used, q[i - 1] == 9'h0FF, "literal");
         end
         send = i < q.size();
         s = send ? q[i] : 9'h0;
         word = mk(10'h140, (i % 3 == 0) ? s : 9'h100, (i % 3 == 1) ? s : 9'h101, (i % 3 == 2) ? s : 9'h102,
                   2'h0, 1'b0, 7'h0, 8'h0);
      end
      $display("selector test done");
   endtask : t_sel

   task automatic t_reset();
      xfer(mk(10'h140, 9'h0, 9'h0, 9'h0, 2'h3, 1'b1, 7'h0, 8'hA5));
      @(negedge mclk);
      rst_n = 1'b0;
      #1;
      cmp({dec_valid, vector_destination, output_multiplier}, 32'h0, "reset");
      repeat (3) @(negedge mclk);
      rst_n = 1'b1;
      // First word, taken at the second rising edge after release, must decode normally
      xfer(mk(10'h16D, 9'h0, 9'h0, 9'h0, 2'h1, 1'b0, 7'h2A, 8'h3C));
      cmp({dec_valid, scalar_result, scalar_destination, vector_destination}, {2'h3, 7'h2A, 8'h3C}, "after reset");
      $display("reset test done");
   endtask : t_reset

   // ********
   // Sequence and watchdog
   // ********
   initial
   begin
      repeat (20) @(negedge mclk);
      rst_n = 1'b1;
      t_fields();
      t_sres();
      t_sel();
      t_reset();
      report_and_stop();
   end

   // About 570 cycles are needed; the ceiling leaves ample margin
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         mismatches++;
         report_and_stop();
      end
   end
endmodule : tb

// ### verif/vtod_chk.sv
// Port-level assertions for the vector three-operand decoder
`timescale 1ns/1ps
module vtod_chk (
   input logic                     mclk,
   input logic                     rst_n,
   input logic                     instr_valid,
   input logic [63:0]              instr_word,
   input logic [31:0]              literal_word,
   input logic                     dec_valid,
   input logic                     format_match,
   input logic                     scalar_result,
   input logic [9:0]               opcode,
   input logic [7:0]               vector_destination,
   input logic [6:0]               scalar_destination,
   input logic                     clamp_flag,
   input vtod_pkg::vtod_outmul_t   output_multiplier,
   input logic                     literal_used,
   input vtod_pkg::vtod_src_kind_t src_kind [3],
   input logic [7:0]               src_index [3],
   input logic [31:0]              src_value [3]
);
   // ********
   // Helpers
   // ********
   logic opc_b;
   // Scalar-result opcode set, kept apart from the design's own table
   assign opc_b = instr_word[25:16] inside {10'h16D, 10'h16E, 10'h176, 10'h177, 10'h30F, 10'h310, 10'h319};
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // ********
   // Checks, each one cycle after the taking edge
   // ********
   property p_valid;
      rst_n |=> dec_valid == $past(instr_valid);
   endproperty
   a_valid: assert property (p_valid) else $error("result strobe not one cycle after take");
   property p_format;
      instr_valid |=> format_match == ($past(instr_word[31:26]) == 6'h35);
   endproperty
   a_format: assert property (p_format) else $error("format match wrong");
   property p_scalar;
      instr_valid && instr_word[40:32] <= 9'h069 |=>
         src_kind[0] == vtod_pkg::VTOD_SRC_SCALAR && src_index[0] == $past(instr_word[39:32]);
   endproperty
   a_scalar: assert property (p_scalar) else $error("first source scalar decode wrong");
   property p_trap;
      instr_valid && instr_word[49:41] inside {[9'h06C:9'h07B]} |=>
         src_kind[1] == vtod_pkg::VTOD_SRC_TRAP && src_index[1] == $past(instr_word[48:41]) - 8'h6C;
   endproperty
   a_trap: assert property (p_trap) else $error("second source trap decode wrong");
   property p_intpos;
      instr_valid && instr_word[58:50] inside {[9'h081:9'h0C0]} |=>
         src_kind[2] == vtod_pkg::VTOD_SRC_INT_CONST && src_value[2] == {23'h0, $past(instr_word[58:50])} - 32'h80;
   endproperty
   a_intpos: assert property (p_intpos) else $error("third source positive constant wrong");
   property p_intneg;
      instr_valid && instr_word[40:32] inside {[9'h0C1:9'h0D0]} |=>
         src_value[0] == 32'hC0 - {23'h0, $past(instr_word[40:32])};
   endproperty
   a_intneg: assert property (p_intneg) else $error("negative constant wrong");
   property p_output_multiplier;
      instr_valid |=> output_multiplier == $past(instr_word[60:59]);
   endproperty
   a_output_multiplier: assert property (p_output_multiplier) else $error("output multiplier wrong");
   property p_sres;
      instr_valid |=> scalar_result == $past(opc_b) &&
         scalar_destination == ($past(opc_b) ? $past(instr_word[14:8]) : 7'h00);
   endproperty
   a_sres: assert property (p_sres) else $error("variant or scalar destination wrong");
   property p_vector_destination;
      instr_valid |=> vector_destination == $past(instr_word[7:0]) && clamp_flag == $past(instr_word[15]);
   endproperty
   a_vector_destination: assert property (p_vector_destination) else $error("destination or clamp wrong");
endmodule : vtod_chk

bind vtod_decoder vtod_chk vtod_chk_inst (.mclk, .rst_n, .instr_valid, .instr_word, .literal_word, .dec_valid,
   .format_match, .scalar_result, .opcode, .vector_destination, .scalar_destination, .clamp_flag,
   .output_multiplier, .literal_used, .src_kind, .src_index, .src_value);

// ### verif/vtod_fetch_model.sv
// Fetch-stage model that feeds words to the decoder on the falling edge
`timescale 1ns/1ps
module vtod_fetch_model (
   input  logic        mclk,
   input  logic        send,
   input  logic [63:0] word,
   input  logic [31:0] lit,
   output logic        instr_valid,
   output logic [63:0] instr_word,
   output logic [31:0] literal_word
);
   // ********
   // Driver
   // ********
   initial {instr_valid, instr_word, literal_word} = '0;
   // Idle lines invert every cycle, so one idle cycle after a word they show its inverse and a held result cannot match them by luck
   always @(negedge mclk)
   begin
      instr_valid  <= send;
      instr_word   <= send ? word : ~instr_word;
      literal_word <= send ? lit : ~literal_word;
   end
endmodule : vtod_fetch_model
